// ==== rtl/adcc_pkg.sv ====
// Constants, register map and types for the conversion sequencer
package adcc_pkg;

  // Register byte offsets on the AXI4-Lite bus
  localparam logic [3:0] ADDR_STATUS_CTRL = 4'h0;
  localparam logic [3:0] ADDR_RESULT_HIGH = 4'h4;
  localparam logic [3:0] ADDR_RESULT_LOW  = 4'h8;
  localparam logic [3:0] ADDR_CLOCK_CFG   = 4'hC;

  // Status and control field positions
  localparam int SC_CH_LSB   = 0;
  localparam int SC_CH_MSB   = 4;
  localparam int SC_CONT_BIT = 5;
  localparam int SC_IRQ_BIT  = 6;
  localparam int SC_FLAG_BIT = 7;

  // Clock configuration field positions
  localparam int CC_ICLK_BIT  = 0;
  localparam int CC_ASYNC_BIT = 1;
  localparam int CC_DIV_LSB   = 2;
  localparam int CC_DIV_MSB   = 3;
  localparam int CC_LSMP_BIT  = 4;
  localparam int CC_MODE_BIT  = 5;
  localparam int CC_HWTRG_BIT = 6;

  localparam logic [4:0]  CH_ALL_ONES   = 5'h1f;
  localparam logic [7:0]  SC_RESET      = 8'h1f;
  localparam logic [7:0]  CC_RESET      = 8'h00;
  localparam logic [9:0]  RESULT_RESET  = 10'h000;
  localparam logic [9:0]  RES10_MAX     = 10'h3ff;
  localparam logic [7:0]  RES8_MAX      = 8'hff;
  localparam logic [10:0] SAR_FIRST     = 11'h400;
  localparam logic [3:0]  SAR_TOP_BIT   = 4'ha;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Conversion clock counts per conversion (subsequent continuous)
  localparam logic [5:0] TICKS_8_SHORT  = 6'd16;
  localparam logic [5:0] TICKS_8_LONG   = 6'd36;
  localparam logic [5:0] TICKS_10_SHORT = 6'd19;
  localparam logic [5:0] TICKS_10_LONG  = 6'd39;
  localparam logic [5:0] TICKS_FIRST    = 6'd2;
  // Sample windows of 3.5 and 23.5 clocks, rounded up to whole ticks
  localparam logic [5:0] SAMPLE_SHORT   = 6'd4;
  localparam logic [5:0] SAMPLE_LONG    = 6'd24;

  // Bus clock figures
  localparam int CLK_PERIOD_PS      = 5000;
  localparam int START_BUS_CYCLES   = 3;
  localparam int ASYNC_STARTUP_NS   = 5000;
  localparam int ASYNC_STARTUP_CYC  =
    (ASYNC_STARTUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int START_W            = 11;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_START = 3'b010,
    ST_RUN   = 3'b100
  } adcc_state_t;

endpackage : adcc_pkg

// ==== rtl/adcc_tick_div.sv ====
// Divider of a source tick stream by 1, 2, 4 or 8
module adcc_tick_div (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       clear,
  input  wire logic       src_tick,
  input  wire logic [1:0] div_sel,
  output logic            tick
);
  import adcc_pkg::*;

  logic [2:0] cnt_q;
  logic [2:0] mask;

  // Division ratio as a count mask
  always_comb begin
    case (div_sel)
      2'd0:    mask = 3'd0;
      2'd1:    mask = 3'd1;
      2'd2:    mask = 3'd3;
      default: mask = 3'd7;
    endcase
  end

  assign tick = src_tick && ((cnt_q & mask) == mask);

  // Clearing keeps the phase aligned to the conversion start
  always_ff @(posedge aclk) begin
    if (!aresetn || clear) begin
      cnt_q <= 3'd0;
    end else if (src_tick) begin
      cnt_q <= cnt_q + 3'd1;
    end
  end

endmodule // adcc_tick_div

// ==== rtl/adcc_top.sv ====
// Successive approximation conversion sequencer with AXI4-Lite registers
module adcc_top #(
  parameter int BUS_SRC_DIV = 4,
  parameter int ALT_SRC_DIV = 8
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [3:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [3:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire logic         hw_trigger,
  input  wire logic         stop_mode,
  input  wire logic         async_clk_src,
  input  wire logic         cmp_above,
  output logic [4:0]        channel_sel,
  output logic [10:0]       dac_code,
  output logic              sample_hold,
  output logic              analog_enable,
  output logic              conv_irq
);
  import adcc_pkg::*;

  adcc_state_t state_q;
  logic [7:0]  sc_q;
  logic [7:0]  cc_q;
  logic [9:0]  result_q;
  logic        flag_q;
  logic        irq_q;
  logic        hi_read_q;
  logic        first_q;
  logic [START_W-1:0] start_cnt_q;
  logic [5:0]  tick_cnt_q;
  logic [10:0] trial_q;
  logic [3:0]  bit_q;
  logic [2:0]  trg_sync_q, stp_sync_q, acs_sync_q;
  logic [1:0]  cmp_sync_q;
  logic [7:0]  src_cnt_q;
  logic        aw_hold_q, w_hold_q;
  logic [3:0]  awaddr_q;
  logic [7:0]  wdata_q;
  logic        wstrb0_q;

  // Pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trg_sync_q <= 3'd0;
      stp_sync_q <= 3'd0;
      acs_sync_q <= 3'd0;
      cmp_sync_q <= 2'd0;
    end else begin
      trg_sync_q <= {trg_sync_q[1:0], hw_trigger};
      stp_sync_q <= {stp_sync_q[1:0], stop_mode};
      acs_sync_q <= {acs_sync_q[1:0], async_clk_src};
      cmp_sync_q <= {cmp_sync_q[0], cmp_above};
    end
  end

  logic trig_edge, stop_lvl, async_edge, cmp_lvl;
  assign trig_edge  = trg_sync_q[1] && !trg_sync_q[2];
  assign stop_lvl   = stp_sync_q[2];
  assign async_edge = acs_sync_q[1] && !acs_sync_q[2];
  assign cmp_lvl    = cmp_sync_q[1];

  // Field views
  logic [4:0] ch_f;
  logic       cont_f, irqen_f, iclk_f, async_f, lsmp_f, mode10_f, hwtrg_f;
  logic [1:0] div_f;
  assign ch_f     = sc_q[SC_CH_MSB:SC_CH_LSB];
  assign cont_f   = sc_q[SC_CONT_BIT];
  assign irqen_f  = sc_q[SC_IRQ_BIT];
  assign iclk_f   = cc_q[CC_ICLK_BIT];
  assign async_f  = cc_q[CC_ASYNC_BIT];
  assign div_f    = cc_q[CC_DIV_MSB:CC_DIV_LSB];
  assign lsmp_f   = cc_q[CC_LSMP_BIT];
  assign mode10_f = cc_q[CC_MODE_BIT];
  assign hwtrg_f  = cc_q[CC_HWTRG_BIT];

  // AXI write: address and data latched in either order
  logic wr_fire;
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign wr_fire       = aw_hold_q && w_hold_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q  <= 1'b0;
      awaddr_q  <= 4'h0;
      wdata_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  // Write decode; a write without the low lane stores nothing
  logic wr_sc, wr_cc, wr_map;
  always_comb begin
    wr_sc  = 1'b0;
    wr_cc  = 1'b0;
    wr_map = 1'b1;
    if (awaddr_q == ADDR_STATUS_CTRL) begin
      wr_sc = wr_fire && wstrb0_q;
    end else if (awaddr_q == ADDR_CLOCK_CFG) begin
      wr_cc = wr_fire && wstrb0_q;
    end else if (awaddr_q == ADDR_RESULT_HIGH || awaddr_q == ADDR_RESULT_LOW) begin
      wr_map = 1'b1;
    end else begin
      wr_map = 1'b0;
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // AXI read: one cycle to data; result reads have side effects
  logic rd_fire, rd_hi, rd_lo;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_hi   = rd_fire && s_axi_araddr == ADDR_RESULT_HIGH;
  assign rd_lo   = rd_fire && s_axi_araddr == ADDR_RESULT_LOW;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      if (s_axi_araddr == ADDR_STATUS_CTRL) begin
        s_axi_rdata <= {24'h00_0000, flag_q, sc_q[SC_IRQ_BIT:SC_CH_LSB]};
      end else if (s_axi_araddr == ADDR_RESULT_HIGH) begin
        s_axi_rdata <= {30'h0000_0000, mode10_f ? result_q[9:8] : 2'b00};
      end else if (s_axi_araddr == ADDR_RESULT_LOW) begin
        s_axi_rdata <= {24'h00_0000, result_q[7:0]};
      end else if (s_axi_araddr == ADDR_CLOCK_CFG) begin
        s_axi_rdata <= {24'h00_0000, 1'b0, cc_q[CC_HWTRG_BIT:CC_ICLK_BIT]};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Configuration registers; the flag bit is never stored from a write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sc_q <= SC_RESET;
      cc_q <= CC_RESET;
    end else begin
      if (wr_sc) begin
        sc_q <= {1'b0, wdata_q[SC_IRQ_BIT:SC_CH_LSB]};
      end
      if (wr_cc) begin
        cc_q <= {1'b0, wdata_q[CC_HWTRG_BIT:CC_ICLK_BIT]};
      end
    end
  end

  assign channel_sel = ch_f;

  // Source ticks for the alternate and bus sources; kept sparse so the
  // synchronised comparator has settled before each decision
  logic bus_src, alt_src, src_tick, conv_tick, running;
  assign running = (state_q == ST_RUN);
  always_ff @(posedge aclk) begin
    if (!aresetn || !running) begin
      src_cnt_q <= 8'd0;
    end else begin
      src_cnt_q <= src_cnt_q + 8'd1;
    end
  end
  assign bus_src = ((src_cnt_q % 8'(BUS_SRC_DIV)) == 8'(BUS_SRC_DIV - 1));
  assign alt_src = ((src_cnt_q % 8'(ALT_SRC_DIV)) == 8'(ALT_SRC_DIV - 1));

  always_comb begin
    if (async_f) begin
      src_tick = async_edge;
    end else if (iclk_f) begin
      src_tick = bus_src;
    end else begin
      src_tick = alt_src;
    end
  end

  // divided conversion clock, stopped while idle
  adcc_tick_div u_div (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .clear    (!running),
    .src_tick (src_tick && running),
    .div_sel  (div_f),
    .tick     (conv_tick)
  );

  // Start and abort causes
  logic sw_start, hw_start, abort, abort_start;
  // software start unless channel all ones or the hardware trigger is selected
  assign sw_start = wr_sc && !hwtrg_f && (wdata_q[SC_CH_MSB:SC_CH_LSB] != CH_ALL_ONES);
  assign abort = wr_sc || wr_cc || (stop_lvl && !async_f);
  assign abort_start = sw_start && !(stop_lvl && !async_f);
  assign hw_start = hwtrg_f && trig_edge && (state_q == ST_IDLE) && !abort;

  // Timing: sample length and total ticks for this conversion
  logic [5:0] smp_len, tot_len;
  always_comb begin
    smp_len = lsmp_f ? SAMPLE_LONG : SAMPLE_SHORT;
    if (mode10_f) begin
      tot_len = lsmp_f ? TICKS_10_LONG : TICKS_10_SHORT;
    end else begin
      tot_len = lsmp_f ? TICKS_8_LONG : TICKS_8_SHORT;
    end
    if (first_q) begin
      tot_len = tot_len + TICKS_FIRST;
    end
  end

  logic last_tick, cmp_tick;
  assign last_tick = running && conv_tick && (tick_cnt_q == tot_len - 6'd1);
  assign cmp_tick  = running && conv_tick && (tick_cnt_q >= smp_len) &&
                     (bit_q != 4'hf);

  // Rounded results
  logic [9:0] res10;
  logic [7:0] res8;
  logic       blocked, done;
  always_comb begin
    res10 = (trial_q[10:1] == RES10_MAX) ? RES10_MAX : trial_q[10:1] + 10'(trial_q[0]);
    res8  = (trial_q[10:3] == RES8_MAX) ? RES8_MAX : trial_q[10:3] + 8'(trial_q[2]);
  end
  assign blocked = last_tick && mode10_f && hi_read_q;
  assign done    = last_tick && !blocked;

  // Sequencer; an abort returns to idle unless it is a software start while no stop abort (stop without the async clock) is active
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q     <= ST_IDLE;
      first_q     <= 1'b0;
      start_cnt_q <= '0;
    end else if (abort) begin
      state_q     <= abort_start ? ST_START : ST_IDLE;
      first_q     <= 1'b1;
      start_cnt_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (hw_start) begin
            state_q     <= ST_START;
            first_q     <= 1'b1;
            start_cnt_q <= '0;
          end
        end
        ST_START: begin
          start_cnt_q <= start_cnt_q + 1'b1;
          // async start-up and three bus clocks of synchronisation
          if (start_cnt_q == START_W'(START_BUS_CYCLES - 1 +
                                      (async_f ? ASYNC_STARTUP_CYC : 0))) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (last_tick) begin
            first_q <= 1'b0;
            // continue or retry, else power down
            if (!(cont_f || blocked)) begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // Tick counter and successive approximation register
  always_ff @(posedge aclk) begin
    if (!aresetn || !running) begin
      tick_cnt_q <= 6'd0;
      trial_q    <= SAR_FIRST;
      bit_q      <= SAR_TOP_BIT;
    end else if (last_tick) begin
      tick_cnt_q <= 6'd0;
      trial_q    <= SAR_FIRST;
      bit_q      <= SAR_TOP_BIT;
    end else if (conv_tick) begin
      tick_cnt_q <= tick_cnt_q + 6'd1;
      if (cmp_tick) begin
        trial_q[bit_q] <= cmp_lvl;
        if (bit_q != 4'h0) begin
          trial_q[bit_q - 4'h1] <= 1'b1;
        end
        bit_q <= bit_q - 4'h1;
      end
    end
  end

  assign dac_code      = trial_q;
  // Sampling drops with the enable, so an abort never leaves the switch closed
  assign sample_hold   = analog_enable && (tick_cnt_q < smp_len);
  assign analog_enable = running && !abort;

  // result transfer; aborts leave the result alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_q <= RESULT_RESET;
    end else if (done && !abort) begin
      result_q <= mode10_f ? res10 : {2'b00, res8};
    end
  end

  // half-read tracking; only a low-half read ends the pairing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hi_read_q <= 1'b0;
    end else if (rd_hi && mode10_f) begin
      hi_read_q <= 1'b1;
    end else if (rd_lo) begin
      hi_read_q <= 1'b0;
    end
  end

  // complete flag and interrupt; set wins over the low-half read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
      irq_q  <= 1'b0;
    end else if (done && !abort) begin
      flag_q <= 1'b1;
      irq_q  <= irqen_f;
    end else if (wr_sc || rd_lo) begin
      flag_q <= 1'b0;
      irq_q  <= 1'b0;
    end else if (!irqen_f) begin
      irq_q  <= 1'b0;
    end
  end

  assign conv_irq = irq_q;

endmodule // adcc_top

// ==== test/adcc_checker.sv ====
// Port-level assertions for the conversion sequencer
module adcc_checker (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        stop_mode,
  input wire logic        sample_hold,
  input wire logic        analog_enable,
  input wire logic        conv_irq
);
  import adcc_pkg::*;
  logic [3:0] adr_q;
  logic [7:0] dat_q;
  logic       stb_q;
  logic       bv_q;
  logic       ien_q;
  logic       asy_q;
  logic       hw_q;
  logic       wr_ok;
  logic       ctl_wr;
  logic       cfg_wr;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Capture each half of a write as the bus takes it
  always_ff @(posedge aclk) begin
    if (s_axi_awvalid && s_axi_awready) adr_q <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) dat_q <= s_axi_wdata[7:0];
    if (s_axi_wvalid && s_axi_wready) stb_q <= s_axi_wstrb[0];
  end
  // First cycle of an accepted, stored write
  assign wr_ok  = s_axi_bvalid && !bv_q && stb_q && (s_axi_bresp == RESP_OKAY);
  assign ctl_wr = wr_ok && (adr_q == ADDR_STATUS_CTRL);
  assign cfg_wr = wr_ok && (adr_q == ADDR_CLOCK_CFG);
  // Shadow enables; one cycle behind the design, harmless at these spacings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bv_q  <= 1'b0;
      ien_q <= 1'b0;
      asy_q <= 1'b0;
      hw_q  <= 1'b0;
    end else begin
      bv_q <= s_axi_bvalid;
      if (ctl_wr) ien_q <= dat_q[SC_IRQ_BIT];
      if (cfg_wr) asy_q <= dat_q[CC_ASYNC_BIT];
      if (cfg_wr) hw_q <= dat_q[CC_HWTRG_BIT];
    end
  end
  a_cfg_abort: assert property (cfg_wr |-> ##[0:2] !analog_enable)
    else $error("conversion survived a clock config write");
  a_ch_idle: assert property (ctl_wr && !hw_q && dat_q[4:0] == CH_ALL_ONES
    |-> ##2 (!analog_enable)[*8]) else $error("conversion ran after idle channel write");
  a_ch_start: assert property (ctl_wr && !hw_q && !asy_q && dat_q[4:0] != CH_ALL_ONES
    |-> ##[0:5] analog_enable) else $error("control write did not start a conversion");
  a_stop_abort: assert property (stop_mode[*4] ##0 !asy_q |-> ##[0:2] !analog_enable)
    else $error("conversion kept running in stop mode");
  a_irq_enable: assert property ($rose(conv_irq) |-> ien_q)
    else $error("interrupt raised while disabled");
  a_irq_cause: assert property ($rose(conv_irq) |-> $past(analog_enable) || $past(analog_enable, 2))
    else $error("completion without a conversion");
  a_sample_power: assert property (sample_hold |-> analog_enable)
    else $error("sampling while powered down");
  a_sample_len: assert property ($rose(sample_hold) |-> (sample_hold || !analog_enable)[*8])
    else $error("sample window too short");
  c_done: cover property ($rose(conv_irq));
  c_cfg_abort: cover property (cfg_wr && analog_enable);
  c_stop: cover property (stop_mode && analog_enable);
endmodule : adcc_checker

bind adcc_top adcc_checker adcc_checker_i (.*);

// ==== test/adcc_analog_model.sv ====
// Analog front end: per-channel level seen through the comparator
module adcc_analog_model (
  input  wire logic        aclk,
  input  wire logic [4:0]  channel_sel,
  input  wire logic [10:0] dac_code,
  input  wire logic        analog_enable,
  output logic             cmp_above
);
  logic [10:0] level;
  logic        junk_q = 1'b0;
  // level of selected input; multiples of eight so both widths round exactly
  assign level = {8'h21 + 8'h13 * {3'h0, channel_sel}, 3'h0};
  // Powered down comparator output is meaningless, so it wanders
  always @(posedge aclk) junk_q <= ~junk_q;
  assign cmp_above = analog_enable ? (level >= dac_code) : junk_q;
endmodule : adcc_analog_model

// ==== test/adcc_top_tb_top.sv ====
// Directed bench for the conversion sequencer over its register bus
module adcc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import adcc_pkg::*;
  localparam int BUS_DIV = 4;
  localparam int ALT_DIV = 8;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, hw_trigger, stop_mode, async_clk_src, cmp_above;
  logic        sample_hold, analog_enable, conv_irq;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [4:0]  channel_sel;
  logic [10:0] dac_code;
  int          bad_count, checks, cyc, t0, lo;
  logic [7:0]  cfgs [5] = '{8'h01, 8'h15, 8'h28, 8'h3d, 8'h22};
  int          nt   [5] = '{18, 38, 21, 41, 21};
  int          per  [5] = '{BUS_DIV, 2 * BUS_DIV, 4 * ALT_DIV, 8 * BUS_DIV, 20};

  adcc_top #(.BUS_SRC_DIV(BUS_DIV), .ALT_SRC_DIV(ALT_DIV)) adcc_top_i (.*);
  adcc_analog_model adcc_analog_model_i (.*);

  // Bus clock and a slow unrelated source of 20 bus cycles
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  initial begin
    async_clk_src = 1'b0;
    forever #50 async_clk_src = ~async_clk_src;
  end
  // Cycle count, also the hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      bad_count++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Address and data offered together, each held until taken
  task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s = 4'hf);
    logic aw, w, b;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h00_0000, d};
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w  = s_axi_wvalid && s_axi_wready;
      b  = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!b);
    s_axi_bready <= 1'b0;
    t0 = cyc;
  endtask

  task automatic rdreg(input logic [3:0] a);
    logic ar, r;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(negedge aclk);
      ar   = s_axi_arvalid && s_axi_arready;
      r    = s_axi_rvalid;
      rd   = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!r);
    s_axi_rready <= 1'b0;
  endtask

  function automatic logic [7:0] lvl(input logic [4:0] ch);
    return 8'h21 + 8'h13 * {3'h0, ch};
  endfunction

  // results read only after completion, high half first
  task automatic res(input logic [4:0] ch, input logic m10);
    logic [7:0] v;
    v = lvl(ch);
    rdreg(ADDR_RESULT_HIGH);
    check(rd, m10 ? {30'h0, v[7:6]} : 32'h0000_0000);
    rdreg(ADDR_RESULT_LOW);
    check(rd, m10 ? {24'h00_0000, v[5:0], 2'h0} : {24'h00_0000, v});
  endtask

  task automatic rst_vals();
    rdreg(ADDR_STATUS_CTRL);
    check(rd, {24'h00_0000, SC_RESET});
    rdreg(ADDR_CLOCK_CFG);
    check(rd, {24'h00_0000, CC_RESET});
    rdreg(ADDR_RESULT_HIGH);
    check(rd, {22'h00_0000, RESULT_RESET});
    rdreg(ADDR_RESULT_LOW);
    check(rd, {22'h00_0000, RESULT_RESET});
    rdreg(4'h2);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    wr(4'h2, 8'h00);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
  endtask

  // Waits for a fresh completion, bounded
  task automatic wait_irq();
    int k;
    for (k = 0; k < 8 && conv_irq === 1'b1; k++) @(negedge aclk);
    for (k = 0; k < 3000 && conv_irq !== 1'b1; k++) @(negedge aclk);
    check(conv_irq, 1'b1);
  endtask

  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {hw_trigger, stop_mode, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    {cyc, bad_count, checks} = '0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rst_vals();
    // first conversion time per mode, source and divider
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_CLOCK_CFG, cfgs[i]);
      wr(ADDR_STATUS_CTRL, {3'h2, 5'(i + 1)});
      wait_irq();
      lo = (nt[i] - 2) * per[i] + (i == 4 ? ASYNC_STARTUP_CYC : 0);
      check(32'(cyc - t0 >= lo && cyc - t0 <= lo + 2 * per[i] + 16), 32'h1);
      res(5'(i + 1), cfgs[i][5]);
      repeat (2) @(negedge aclk);
      check(conv_irq, 1'b0);
    end
    wr(ADDR_CLOCK_CFG, 8'h01);
    wr(ADDR_STATUS_CTRL, 8'h62);
    wait_irq();
    t0 = cyc;
    rdreg(ADDR_RESULT_LOW);
    wait_irq();
    check(32'(cyc - t0 >= 14 * BUS_DIV && cyc - t0 <= 16 * BUS_DIV + 8), 32'h1);
    wr(ADDR_STATUS_CTRL, 8'h1f);
    repeat (100) @(negedge aclk);
    check(analog_enable, 1'b0);
    res(5'h2, 1'b0);
    wr(ADDR_CLOCK_CFG, 8'h21);
    wr(ADDR_STATUS_CTRL, 8'h44);
    rdreg(ADDR_RESULT_HIGH);
    repeat (130) @(negedge aclk);
    check(conv_irq, 1'b0);
    check(analog_enable, 1'b1);
    rdreg(ADDR_RESULT_LOW);
    check(rd, {24'h00_0000, lvl(5'h2)});
    wait_irq();
    res(5'h4, 1'b1);
    // clock write aborts; strobe-less write ignored
    wr(ADDR_STATUS_CTRL, 8'h41);
    repeat (40) @(negedge aclk);
    wr(ADDR_STATUS_CTRL, 8'h5f, 4'h0);
    @(negedge aclk);
    check(analog_enable, 1'b1);
    wr(ADDR_CLOCK_CFG, 8'h21);
    repeat (150) @(negedge aclk);
    check(conv_irq, 1'b0);
    res(5'h4, 1'b1);
    // stop entry without async clock aborts
    wr(ADDR_STATUS_CTRL, 8'h43);
    repeat (40) @(posedge aclk);
    stop_mode <= 1'b1;
    repeat (8) @(posedge aclk);
    stop_mode <= 1'b0;
    repeat (150) @(negedge aclk);
    check(conv_irq, 1'b0);
    check(analog_enable, 1'b0);
    res(5'h4, 1'b1);
    // trigger edge starts, register write does not
    wr(ADDR_CLOCK_CFG, 8'h41);
    wr(ADDR_STATUS_CTRL, 8'h45);
    repeat (30) @(posedge aclk);
    hw_trigger <= 1'b1;
    @(negedge aclk);
    check(analog_enable, 1'b0);
    repeat (6) @(posedge aclk);
    hw_trigger <= 1'b0;
    wait_irq();
    res(5'h5, 1'b0);
    wr(ADDR_CLOCK_CFG, 8'h21);
    wr(ADDR_STATUS_CTRL, 8'h43);
    repeat (30) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check(analog_enable, 1'b0);
    rst_vals();
    print_verdict();
  end
endmodule : adcc_top_tb_top
